// ---- fbsl_pkg.sv ----
// Package with register map, field layout, timing and carrier types of the fan smoothing block.
package fbsl_pkg;

    typedef logic signed [15:0] fbsl_temp_t;

    localparam int CLK_NS = 40;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    // Register indexes; the byte address is four times the index.
    localparam logic [7:0] IDX_BOOST_HYST = 8'hC1;
    localparam logic [7:0] IDX_SMOOTH     = 8'hC2;
    localparam logic [7:0] IDX_TABLE12    = 8'hC3;
    localparam logic [7:0] IDX_TABLE34    = 8'hC4;
    localparam logic [7:0] IDX_SPECIAL    = 8'hD0;
    localparam logic [7:0] IDX_FILT1      = 8'hD1;
    localparam logic [7:0] IDX_FILT2      = 8'hD2;

    localparam logic [7:0] RST_BOOST_HYST = 8'h44;
    localparam logic [7:0] RST_ZERO       = 8'h00;

    localparam int NIB_LO_LSB    = 0;
    localparam int NIB_HI_LSB    = 4;
    localparam int NIB_W         = 4;
    localparam int SPAN1_LSB     = 0;
    localparam int EN1_BIT       = 3;
    localparam int SPAN2_LSB     = 4;
    localparam int EN2_BIT       = 7;
    localparam int SPAN_W        = 3;
    localparam int SFC_RES12_BIT = 4;
    localparam int SFC_RES34_BIT = 5;

    // Temperatures carry four fraction bits (1/16 degree C).
    localparam int HYST_SHIFT_COARSE = 4;
    localparam int HYST_SHIFT_FINE   = 3;

    // Filter step period base: 25 ms, so a span in tenths of a second counts quarter-span steps.
    localparam int TICK_NS     = 25_000_000;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;
    localparam int TICK_W      = 20;
    localparam int FILT_SHIFT  = 2;

    localparam logic [6:0] SPAN0_DS = 7'd118;
    localparam logic [6:0] SPAN1_DS = 7'd70;
    localparam logic [6:0] SPAN2_DS = 7'd44;
    localparam logic [6:0] SPAN3_DS = 7'd30;
    localparam logic [6:0] SPAN4_DS = 7'd16;
    localparam logic [6:0] SPAN5_DS = 7'd8;
    localparam logic [6:0] SPAN6_DS = 7'd6;
    localparam logic [6:0] SPAN7_DS = 7'd4;

    localparam logic [3:0] LUT_STEPS           = 4'hD;
    localparam logic [7:0] STEP_DUTY_INC       = 8'h15;
    localparam logic [7:0] FLOOR_UNMAPPED_DUTY = 8'hFF;

    typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} fbsl_bus_t;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [DATA_W-1:0] writedata;
        logic [3:0]        byteenable;
    } fbsl_avs_req_t;

    typedef struct packed {
        fbsl_temp_t temp;
        fbsl_temp_t boost;
    } fbsl_boost_in_t;

    typedef struct packed {
        fbsl_temp_t temp;
        fbsl_temp_t base;
        logic [3:0] step_req;
    } fbsl_table_in_t;

    function automatic logic [6:0] fbsl_span(input logic [2:0] code);
        case (code)
            3'h0:    return SPAN0_DS;
            3'h1:    return SPAN1_DS;
            3'h2:    return SPAN2_DS;
            3'h3:    return SPAN3_DS;
            3'h4:    return SPAN4_DS;
            3'h5:    return SPAN5_DS;
            3'h6:    return SPAN6_DS;
            default: return SPAN7_DS;
        endcase
    endfunction

    function automatic logic [7:0] fbsl_duty(input logic [3:0] code);
        if (code >= LUT_STEPS)
            return FLOOR_UNMAPPED_DUTY;
        return 8'({4'h0, code} * STEP_DUTY_INC);
    endfunction

endpackage

// ---- fbsl_core.sv ----
// Fan boost hysteresis, zone smoothing filters and table floor duty with step hysteresis.
`timescale 1ns/1ns

// Operation
// - Zone 3 low, zone 4 high boost nibble
// - Hold full duty until below boost minus hysteresis
// - Boost hysteresis unsigned zero to fifteen degrees
// - Zone 1 enable selects filtered control temperature
// - Zone 2 enable selects filtered control temperature
// - Filter always runs and stays readable
// - Reading temperature stays raw while smoothing
// - Zone 1 span from low three bits
// - Zone 2 span upper bits, eight spans
// - Smoothing follows converter averaging
// - Tables 1/2 step hysteresis low nibble
// - Special bit 4 sets tables 1/2 resolution
// - Tables 3/4 hysteresis, special bit 5 resolution
// - Below base, tables 1/2 request floor duty
// - Below base, tables 3/4 request floor duty
// - Thirteen floor codes map through step table
module fbsl_core
    import fbsl_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
    input  wire logic                       SYS_CLK,
    input  wire logic                       RESET_N,
    input  wire fbsl_avs_req_t              AVS_REQ,
    output logic [DATA_W-1:0]               AVS_READDATA,
    output logic                            AVS_WAITREQUEST,
    input  wire fbsl_temp_t [1:0]           ZONE_RAW_TEMP,
    input  wire logic [1:0]                 ZONE_RAW_VALID,
    output fbsl_temp_t [1:0]                ZONE_READ_TEMP,
    output fbsl_temp_t [1:0]                ZONE_FILT_TEMP,
    output fbsl_temp_t [1:0]                ZONE_CTRL_TEMP,
    input  wire fbsl_boost_in_t [1:0]       BOOST_IN,
    output logic [1:0]                      BOOST_FULL_DUTY,
    input  wire fbsl_table_in_t [3:0]       TABLE_IN,
    output logic [3:0][3:0]                 TABLE_STEP,
    output logic [3:0][7:0]                 TABLE_DUTY
);

    typedef struct packed {
        fbsl_bus_t              bus_state;
        logic                   waitreq;
        logic [DATA_W-1:0]      rdata;
        logic [7:0]             boost_hyst;
        logic [7:0]             smooth_ctl;
        logic [7:0]             table12;
        logic [7:0]             table34;
        logic [7:0]             special;
        logic [TICK_W-1:0]      tick_cnt;
        logic                   tick;
        logic [1:0][6:0]        span_cnt;
        logic [1:0]             primed;
        fbsl_temp_t [1:0]       raw;
        fbsl_temp_t [1:0]       filt;
        fbsl_temp_t [1:0]       ctrl;
        logic [1:0]             boost_on;
        logic [3:0][3:0]        step;
        fbsl_temp_t [3:0]       entry;
        logic [3:0][7:0]        duty;
    } fbsl_state_t;

    fbsl_state_t s;
    fbsl_state_t next_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb
    begin
        logic [7:0]          idx;
        logic [DATA_W-1:0]   rd;
        logic [1:0]          en;
        logic [1:0][2:0]     span;
        logic signed [16:0]  diff;
        logic signed [16:0]  lower;
        logic [7:0]          pair;
        logic                fine;
        logic [3:0]          hyst;
        logic signed [16:0]  hyst_eff;
        idx      = AVS_REQ.address[ADDR_W-1:2];
        rd       = '0;
        en       = '0;
        span[0]  = s.smooth_ctl[SPAN1_LSB +: SPAN_W];
        span[1]  = s.smooth_ctl[SPAN2_LSB +: SPAN_W];
        diff     = '0;
        lower    = '0;
        pair     = '0;
        fine     = 1'b0;
        hyst     = '0;
        hyst_eff = '0;
        next_s   = s;
        next_s.tick = 1'b0;

        // Read data is captured when the request is first seen, so it stands in the answer cycle.
        case (idx)
            IDX_BOOST_HYST: rd[7:0] = s.boost_hyst;
            IDX_SMOOTH:     rd[7:0] = s.smooth_ctl;
            IDX_TABLE12:    rd[7:0] = s.table12;
            IDX_TABLE34:    rd[7:0] = s.table34;
            IDX_SPECIAL:    rd[7:0] = s.special;
            IDX_FILT1:      rd[15:0] = s.filt[0];
            IDX_FILT2:      rd[15:0] = s.filt[1];
            default:        rd = '0;
        endcase

        case (s.bus_state)
            BUS_IDLE:
            begin
                if (AVS_REQ.read || AVS_REQ.write)
                begin
                    next_s.bus_state = BUS_ACK;
                    next_s.waitreq   = 1'b0;
                    next_s.rdata     = AVS_REQ.read ? rd : '0;
                end
            end
            BUS_ACK:
            begin
                next_s.bus_state = BUS_IDLE;
                next_s.waitreq   = 1'b1;
                if (AVS_REQ.write && AVS_REQ.byteenable[0])
                begin
                    case (idx)
                        IDX_BOOST_HYST: next_s.boost_hyst = AVS_REQ.writedata[7:0];
                        IDX_SMOOTH:     next_s.smooth_ctl = AVS_REQ.writedata[7:0];
                        IDX_TABLE12:    next_s.table12    = AVS_REQ.writedata[7:0];
                        IDX_TABLE34:    next_s.table34    = AVS_REQ.writedata[7:0];
                        IDX_SPECIAL:    next_s.special    = AVS_REQ.writedata[7:0];
                        default:        next_s.special    = s.special;
                    endcase
                end
            end
            default:
            begin
                next_s.bus_state = BUS_IDLE;
                next_s.waitreq   = 1'b1;
            end
        endcase

        // The control source follows an enable written in this same cycle, so a switch
        // never shows one stale sample from the old source.
        en = {next_s.smooth_ctl[EN2_BIT], next_s.smooth_ctl[EN1_BIT]};

        if (s.tick_cnt == TICK_W'(TICK_CYCLES_P - 1))
        begin
            next_s.tick_cnt = '0;
            next_s.tick     = 1'b1;
        end
        else
            next_s.tick_cnt = s.tick_cnt + TICK_W'(1);

        // The incoming samples are already averaged by the converter; smoothing acts on top.
        for (int z = 0; z < 2; z++)
        begin
            if (ZONE_RAW_VALID[z])
            begin
                next_s.raw[z] = ZONE_RAW_TEMP[z];
                if (!s.primed[z])
                begin
                    next_s.filt[z]   = ZONE_RAW_TEMP[z];
                    next_s.primed[z] = 1'b1;
                end
            end
            // The filter steps whether or not its enable is set.
            if (s.tick && s.primed[z])
            begin
                if (s.span_cnt[z] >= fbsl_span(span[z]) - 7'd1)
                begin
                    next_s.span_cnt[z] = '0;
                    diff = {s.raw[z][15], s.raw[z]} - {s.filt[z][15], s.filt[z]};
                    next_s.filt[z] = s.filt[z] + 16'(diff >>> FILT_SHIFT);
                end
                else
                    next_s.span_cnt[z] = s.span_cnt[z] + 7'd1;
            end
            next_s.ctrl[z] = en[z] ? next_s.filt[z] : next_s.raw[z];
        end

        for (int b = 0; b < 2; b++)
        begin
            hyst  = (b == 0) ? s.boost_hyst[NIB_LO_LSB +: NIB_W]
                             : s.boost_hyst[NIB_HI_LSB +: NIB_W];
            lower = {BOOST_IN[b].temp[15], BOOST_IN[b].temp}
                  + $signed({9'h000, hyst, 4'h0});
            if (BOOST_IN[b].temp > BOOST_IN[b].boost)
                next_s.boost_on[b] = 1'b1;
            // Both sides are signed so that temperatures below zero compare correctly.
            else if (lower < $signed({BOOST_IN[b].boost[15], BOOST_IN[b].boost}))
                next_s.boost_on[b] = 1'b0;
        end

        for (int t = 0; t < 4; t++)
        begin
            pair     = (t < 2) ? s.table12 : s.table34;
            fine     = (t < 2) ? s.special[SFC_RES12_BIT] : s.special[SFC_RES34_BIT];
            hyst     = pair[NIB_LO_LSB +: NIB_W];
            // Widen before shifting, otherwise the upper hysteresis bits fall off.
            hyst_eff = fine ? $signed(17'(hyst) << HYST_SHIFT_FINE)
                            : $signed(17'(hyst) << HYST_SHIFT_COARSE);
            lower    = {TABLE_IN[t].temp[15], TABLE_IN[t].temp} + hyst_eff;
            // Stepping up is immediate; stepping down waits for the hysteresis margin.
            if (TABLE_IN[t].step_req > s.step[t])
            begin
                next_s.step[t]  = TABLE_IN[t].step_req;
                next_s.entry[t] = TABLE_IN[t].temp;
            end
            else if (TABLE_IN[t].step_req < s.step[t]
                     && lower < $signed({s.entry[t][15], s.entry[t]}))
            begin
                next_s.step[t]  = TABLE_IN[t].step_req;
                next_s.entry[t] = TABLE_IN[t].temp;
            end
            if (TABLE_IN[t].temp < TABLE_IN[t].base)
                next_s.duty[t] = fbsl_duty(pair[NIB_HI_LSB +: NIB_W]);
            else
                next_s.duty[t] = fbsl_duty(next_s.step[t]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s            <= '0;
            s.bus_state  <= BUS_IDLE;
            s.waitreq    <= 1'b1;
            s.boost_hyst <= RST_BOOST_HYST;
            s.smooth_ctl <= RST_ZERO;
            s.table12    <= RST_ZERO;
            s.table34    <= RST_ZERO;
            s.special    <= RST_ZERO;
        end
        else
            s <= next_s;
    end

    assign AVS_READDATA    = s.rdata;
    assign AVS_WAITREQUEST = s.waitreq;
    assign ZONE_READ_TEMP  = s.raw;
    assign ZONE_FILT_TEMP  = s.filt;
    assign ZONE_CTRL_TEMP  = s.ctrl;
    assign BOOST_FULL_DUTY = s.boost_on;
    assign TABLE_STEP      = s.step;
    assign TABLE_DUTY      = s.duty;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_req_seen;
        s.bus_state == BUS_IDLE && (AVS_REQ.read || AVS_REQ.write);
    endsequence

    sequence s_answer;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence

    a_bus_answer: assert property (s_req_seen |=> s_answer)
        else $error("bus request not answered in one cycle");

    a_boost_write: assert property (s.bus_state == BUS_ACK && AVS_REQ.write
        && AVS_REQ.byteenable[0] && AVS_REQ.address[ADDR_W-1:2] == IDX_BOOST_HYST
        |=> s.boost_hyst == $past(AVS_REQ.writedata[7:0]))
        else $error("boost hysteresis write lost");

    a_boost_set: assert property (BOOST_IN[0].temp > BOOST_IN[0].boost
        |=> BOOST_FULL_DUTY[0])
        else $error("zone 3 boost not entered");

    a_boost_hold: assert property (BOOST_FULL_DUTY[1]
        && !(({BOOST_IN[1].temp[15], BOOST_IN[1].temp}
        + $signed({9'h000, s.boost_hyst[NIB_HI_LSB +: NIB_W], 4'h0}))
        < {BOOST_IN[1].boost[15], BOOST_IN[1].boost}) |=> BOOST_FULL_DUTY[1])
        else $error("zone 4 boost released inside hysteresis");

    a_ctrl_zone1: assert property (ZONE_CTRL_TEMP[0] ==
        (s.smooth_ctl[EN1_BIT] ? ZONE_FILT_TEMP[0] : ZONE_READ_TEMP[0]))
        else $error("zone 1 control temperature source wrong");

    a_ctrl_zone2: assert property (ZONE_CTRL_TEMP[1] ==
        (s.smooth_ctl[EN2_BIT] ? ZONE_FILT_TEMP[1] : ZONE_READ_TEMP[1]))
        else $error("zone 2 control temperature source wrong");

    a_filter_runs: assert property (s.tick && s.primed[0] && !s.smooth_ctl[EN1_BIT]
        && s.span_cnt[0] >= fbsl_span(s.smooth_ctl[SPAN1_LSB +: SPAN_W]) - 7'd1
        && (ZONE_READ_TEMP[0] - ZONE_FILT_TEMP[0] > 16'sh0004)
        |=> ZONE_FILT_TEMP[0] > $past(ZONE_FILT_TEMP[0]))
        else $error("zone 1 filter stalled while disabled");

    a_raw_report: assert property (ZONE_RAW_VALID[1]
        |=> ZONE_READ_TEMP[1] == $past(ZONE_RAW_TEMP[1]))
        else $error("reading temperature not raw");

    a_span_bound: assert property (s.span_cnt[1] < fbsl_span(s.smooth_ctl[SPAN2_LSB +: SPAN_W])
        || $changed(s.smooth_ctl))
        else $error("zone 2 span counter overran");

    a_step_hold: assert property (TABLE_IN[2].step_req < s.step[2]
        && TABLE_IN[2].temp >= s.entry[2] |=> $stable(s.step[2]))
        else $error("table 3 stepped down without margin");

    a_floor_duty: assert property (TABLE_IN[0].temp < TABLE_IN[0].base
        |=> TABLE_DUTY[0] == fbsl_duty($past(s.table12[NIB_HI_LSB +: NIB_W])))
        else $error("table 1 floor duty wrong");

    a_floor_34: assert property (TABLE_IN[3].temp < TABLE_IN[3].base
        && s.table34[NIB_HI_LSB +: NIB_W] == 4'h2 |=> TABLE_DUTY[3] == 8'h2A)
        else $error("table 4 floor duty wrong");

    a_unmapped_duty: assert property (TABLE_IN[1].temp < TABLE_IN[1].base
        && s.table12[NIB_HI_LSB +: NIB_W] >= LUT_STEPS |=> TABLE_DUTY[1] == FLOOR_UNMAPPED_DUTY)
        else $error("unmapped floor code not full duty");

    ////////////////////////////////////////////////////////////////////////////////
    // Further checks on the bus, the boost outputs, the filters and the tables.

    sequence s_read_table12;
        s_req_seen ##0 AVS_REQ.read && AVS_REQ.address[ADDR_W-1:2] == IDX_TABLE12;
    endsequence

    a_ack_low: assert property (s.bus_state == BUS_ACK |-> !AVS_WAITREQUEST)
        else $error("answer cycle without waitrequest low");

    a_idle_wait: assert property (s.bus_state == BUS_IDLE |-> AVS_WAITREQUEST)
        else $error("waitrequest low while idle");

    a_read_data: assert property (s_read_table12
        |=> AVS_READDATA == {24'h00_0000, $past(s.table12)})
        else $error("table 1/2 read data wrong");

    a_be_refused: assert property (s.bus_state == BUS_ACK && AVS_REQ.write
        && !AVS_REQ.byteenable[0] |=> $stable(s.boost_hyst) && $stable(s.table12))
        else $error("write without byte enable landed");

    a_zone3_clear: assert property (!(BOOST_IN[0].temp > BOOST_IN[0].boost)
        && $signed({BOOST_IN[0].temp[15], BOOST_IN[0].temp})
        + $signed({9'h000, s.boost_hyst[NIB_LO_LSB +: NIB_W], 4'h0})
        < $signed({BOOST_IN[0].boost[15], BOOST_IN[0].boost}) |=> !BOOST_FULL_DUTY[0])
        else $error("zone 3 boost not released");

    a_zone4_set: assert property (BOOST_IN[1].temp > BOOST_IN[1].boost
        |=> BOOST_FULL_DUTY[1])
        else $error("zone 4 boost not entered");

    a_zone1_preload: assert property (ZONE_RAW_VALID[0] && !s.primed[0]
        |=> ZONE_FILT_TEMP[0] == $past(ZONE_RAW_TEMP[0]))
        else $error("zone 1 filter not preloaded");

    a_read_zone1: assert property (ZONE_RAW_VALID[0]
        |=> ZONE_READ_TEMP[0] == $past(ZONE_RAW_TEMP[0]))
        else $error("zone 1 reading temperature not raw");

    a_tick_wrap: assert property (s.tick |-> s.tick_cnt == '0)
        else $error("filter tick out of phase");

    a_step_up: assert property (TABLE_IN[1].step_req > s.step[1]
        |=> TABLE_STEP[1] == $past(TABLE_IN[1].step_req))
        else $error("table 2 step up delayed");

    a_step_duty: assert property (!(TABLE_IN[2].temp < TABLE_IN[2].base)
        |=> TABLE_DUTY[2] == fbsl_duty(TABLE_STEP[2]))
        else $error("table 3 duty not from step");

    a_floor_t2: assert property (TABLE_IN[1].temp < TABLE_IN[1].base
        && s.table12[NIB_HI_LSB +: NIB_W] == 4'h1 |=> TABLE_DUTY[1] == 8'h15)
        else $error("table 2 floor duty wrong");

    a_unmapped_34: assert property (TABLE_IN[3].temp < TABLE_IN[3].base
        && s.table34[NIB_HI_LSB +: NIB_W] >= LUT_STEPS |=> TABLE_DUTY[3] == FLOOR_UNMAPPED_DUTY)
        else $error("table 4 unmapped floor code not full duty");

endmodule

// ---- fan_boost_smoothing_lut_cfg_tb.sv ----
// Self-checking testbench for the fan boost, smoothing and table floor duty block.
`timescale 1ns/1ns
module fan_boost_smoothing_lut_cfg_tb import fbsl_pkg::*;;
    localparam int LIMIT = 6000;
    logic                 sys_clk;
    logic                 reset_n;
    fbsl_avs_req_t        req;
    logic [DATA_W-1:0]    rdata;
    logic                 wait_req;
    fbsl_temp_t [1:0]     raw_temp;
    logic [1:0]           raw_valid;
    fbsl_temp_t [1:0]     read_temp;
    fbsl_temp_t [1:0]     filt_temp;
    fbsl_temp_t [1:0]     ctrl_temp;
    fbsl_boost_in_t [1:0] boost_in;
    logic [1:0]           full_duty;
    fbsl_table_in_t [3:0] table_in;
    logic [3:0][3:0]      step;
    logic [3:0][7:0]      duty;
    int                   n_mismatch = 0;
    int                   samples_checked = 0;
    int                   cycles = 0;
    logic [7:0]           seed = 8'h06;
    logic [31:0]          rd;

    fbsl_core #(.TICK_CYCLES_P(4)) dut (
        .SYS_CLK         (sys_clk),
        .RESET_N         (reset_n),
        .AVS_REQ         (req),
        .AVS_READDATA    (rdata),
        .AVS_WAITREQUEST (wait_req),
        .ZONE_RAW_TEMP   (raw_temp),
        .ZONE_RAW_VALID  (raw_valid),
        .ZONE_READ_TEMP  (read_temp),
        .ZONE_FILT_TEMP  (filt_temp),
        .ZONE_CTRL_TEMP  (ctrl_temp),
        .BOOST_IN        (boost_in),
        .BOOST_FULL_DUTY (full_duty),
        .TABLE_IN        (table_in),
        .TABLE_STEP      (step),
        .TABLE_DUTY      (duty)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Codes past the last table step are expected to give full duty.
    function automatic logic [7:0] duty_of(input logic [3:0] c);
        return (c < 4'hD) ? 8'(c * 8'h15) : 8'hFF;
    endfunction

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== {16'h0000, exp})
        begin
            n_mismatch++;
            $display("[ERR] %0t register read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_port(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Request is held until waitrequest is sampled low; read data is taken at that edge.
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        req.address    <= ADDR_W'({idx, 2'b00});
        req.read       <= ~wr;
        req.write      <= wr;
        req.writedata  <= {24'h00_0000, wd};
        req.byteenable <= 4'hF;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wait_req !== 1'b0 && n < 50);
        rd = rdata;
        req.read  <= 1'b0;
        req.write <= 1'b0;
        if (n >= 50)
        begin
            n_mismatch++;
            $display("[ERR] %0t bus answer missing", $time);
        end
    endtask

    task automatic feed(input int z, input fbsl_temp_t v);
        @(posedge sys_clk);
        raw_temp[z]  <= v;
        raw_valid[z] <= 1'b1;
        @(posedge sys_clk);
        raw_valid[z] <= 1'b0;
        #1;
    endtask

    task automatic wait_filt(input int z, input fbsl_temp_t prev);
        int n;
        n = 0;
        while (filt_temp[z] === prev && n < 24)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask

    task automatic drive_boost(input int z, input fbsl_temp_t t);
        @(posedge sys_clk);
        boost_in[z] <= '{t, 16'h0500};
        settle(2);
    endtask

    task automatic drive_table(input int t, input fbsl_temp_t tp, input logic [3:0] s);
        @(posedge sys_clk);
        table_in[t] <= '{tp, 16'h0000, s};
        settle(2);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #(CLK_NS / 2) sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            n_mismatch++;
            $display("[ERR] %0t run exceeded its cycle budget", $time);
            report_and_stop;
        end
    end

    initial
    begin
        logic [3:0] h [2];
        logic [3:0] hv;
        fbsl_temp_t he;
        reset_n   = 1'b0;
        req       = '0;
        raw_temp  = '0;
        raw_valid = '0;
        boost_in  = '0;
        table_in  = '0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            bus(IDX_BOOST_HYST + 8'(i), 1'b0, 8'h00);
            chk_reg(rd, (i == 0) ? {8'h00, RST_BOOST_HYST} : 16'h0000);
        end
        bus(8'hC5, 1'b0, 8'h00);
        chk_reg(rd, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            bus(IDX_BOOST_HYST + 8'(i % 4), 1'b1, seed);
            bus(IDX_BOOST_HYST + 8'(i % 4), 1'b0, 8'h00);
            chk_reg(rd, {8'h00, seed});
        end
        ////////////////////////////////////////////////////////////////////////////
        seed = lfsr(seed);
        h[0] = seed[3:0];
        h[1] = 4'hF;
        bus(IDX_BOOST_HYST, 1'b1, {h[1], h[0]});
        for (int z = 0; z < 2; z++)
        begin
            he = fbsl_temp_t'(16'h0500 - {8'h00, h[z], 4'h0});
            drive_boost(z, 16'h0501);
            chk_port({15'h0000, full_duty[z]}, 16'h0001, "boost on");
            drive_boost(z, he);
            chk_port({15'h0000, full_duty[z]}, 16'h0001, "boost held");
            drive_boost(z, he - 16'h0001);
            chk_port({15'h0000, full_duty[z]}, 16'h0000, "boost off");
        end
        ////////////////////////////////////////////////////////////////////////////
        for (int z = 0; z < 2; z++)
        begin
            bus(IDX_SMOOTH, 1'b1, z ? 8'h70 : 8'h07);
            feed(z, 16'h0400);
            settle(2);
            chk_port(filt_temp[z], 16'h0400, "filt preload");
            feed(z, 16'h0800);
            wait_filt(z, 16'h0400);
            settle(2);
            chk_port(filt_temp[z], 16'h0500, "filt step");
            chk_port(read_temp[z], 16'h0800, "read raw");
            chk_port(ctrl_temp[z], 16'h0800, "ctrl raw");
            bus(IDX_FILT1 + 8'(z), 1'b0, 8'h00);
            chk_reg(rd, 16'h0500);
            // Raw equal to the filter value freezes it, so the enable check sees one known step.
            feed(z, 16'h0500);
            bus(IDX_SMOOTH, 1'b1, z ? 8'hF0 : 8'h0F);
            feed(z, 16'h0900);
            wait_filt(z, 16'h0500);
            settle(2);
            chk_port(ctrl_temp[z], 16'h0600, "ctrl filtered");
            chk_port(read_temp[z], 16'h0900, "read unfiltered");
        end
        ////////////////////////////////////////////////////////////////////////////
        for (int t = 0; t < 4; t++)
            table_in[t] <= '{16'h0100, 16'h7000, 4'h0};
        for (int c = 0; c < 16; c++)
        begin
            bus(IDX_TABLE12, 1'b1, {c[3:0], 4'h1});
            bus(IDX_TABLE34, 1'b1, {c[3:0], 4'h1});
            settle(2);
            for (int t = 0; t < 4; t++)
                chk_port({8'h00, duty[t]}, {8'h00, duty_of(c[3:0])}, "floor");
        end
        seed = lfsr(seed);
        bus(IDX_SPECIAL, 1'b1, 8'h20);
        bus(IDX_TABLE12, 1'b1, {4'h0, seed[3:0] | 4'h1});
        bus(IDX_TABLE34, 1'b1, {4'h0, seed[7:4] | 4'h1});
        for (int t = 0; t < 4; t++)
        begin
            hv = (t < 2) ? (seed[3:0] | 4'h1) : (seed[7:4] | 4'h1);
            he = (t < 2) ? {8'h00, hv, 4'h0} : {9'h000, hv, 3'h0};
            drive_table(t, 16'h0300, 4'h5);
            chk_port({12'h000, step[t]}, 16'h0005, "step up");
            chk_port({8'h00, duty[t]}, 16'h0069, "step duty");
            drive_table(t, 16'h0300, 4'h3);
            chk_port({12'h000, step[t]}, 16'h0005, "step held");
            drive_table(t, 16'h0300 - he, 4'h3);
            chk_port({12'h000, step[t]}, 16'h0005, "step edge");
            drive_table(t, 16'h0300 - he - 16'h0001, 4'h3);
            chk_port({12'h000, step[t]}, 16'h0003, "step down");
            chk_port({8'h00, duty[t]}, 16'h003F, "down duty");
        end
        report_and_stop;
    end
endmodule
